// ### inc/tsa_regs.svh
// Constants for the two-step converter control block
// Assumes inclusion by bare name from the package and modules
`ifndef TSA_REGS_SVH
`define TSA_REGS_SVH
`define TSA_DATA_W        10
`define TSA_COARSE_W      4
`define TSA_FINE_W        6
`define TSA_CODE_MAX      10'h3FF
`define TSA_CODE_MIN      10'h000
`define TSA_SAMPLE_W      12
`define TSA_LATENCY       2
`define TSA_CLK_NS        5
`define TSA_APERTURE_NS   35
`define TSA_APERTURE_CYC  ((`TSA_APERTURE_NS + `TSA_CLK_NS - 1) / `TSA_CLK_NS)
`define TSA_BUF_DEPTH     2
`endif

// ### inc/tsa_pkg.sv
// Types for the two-step converter control block
// Assumes the constants header is on the include path
`include "tsa_regs.svh"
package tsa_pkg;
  typedef enum logic [1:0] {
    TSA_IDLE,
    TSA_COARSE,
    TSA_FINE
  } tsa_state_t;
  typedef logic [`TSA_DATA_W-1:0] tsa_code_t;
endpackage

// ### inc/tsa_buf_if.sv
// Valid/ready carrier between converter core and output buffer
// Assumes one clock shared by both ends
`timescale 1ns/1ps
interface tsa_buf_if;
  import tsa_pkg::*;
  logic      valid;
  logic      ready;
  tsa_code_t code;
  logic      ovf;
  modport src (output valid, output code, output ovf, input ready);
  modport snk (input valid, input code, input ovf, output ready);
endinterface

// ### verilog/tsa_out_buf.sv
// Two-entry output buffer holding code and range flag together
// Assumes synchronous active-high reset and a single clock
`timescale 1ns/1ps
`include "tsa_regs.svh"
module tsa_out_buf
  import tsa_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  tsa_buf_if.snk          up,
  output      logic       out_valid_out,
  input  wire logic       out_ready_in,
  output      tsa_code_t  out_code_out,
  output      logic       out_ovf_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [`TSA_DATA_W:0] mem_r   [`TSA_BUF_DEPTH];
  logic [`TSA_DATA_W:0] mem_nxt [`TSA_BUF_DEPTH];
  logic                 wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0]           cnt_r, cnt_nxt;
  logic                 push, pop;

  // Pointer and storage next state
  always_comb begin
    push    = up.valid && (cnt_r != 2'h2);
    pop     = out_ready_in && (cnt_r != 2'h0);
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    if (push) begin
      mem_nxt[wp_r] = {up.ovf, up.code};
      wp_nxt        = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  // Registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
      mem_r <= '{default: '0};
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end

  // Honest full and empty
  assign up.ready      = (cnt_r != 2'h2);
  assign out_valid_out = (cnt_r != 2'h0);
  assign out_code_out  = mem_r[rp_r][`TSA_DATA_W-1:0];
  assign out_ovf_out   = mem_r[rp_r][`TSA_DATA_W];
endmodule

// ### verilog/tsa_conv_ctrl.sv
// Clocked conversion control of a ten-bit two-step flash converter
// Assumes the sampled input word arrives synchronous to clk_in
//
// Summary of operation
// [R01] Code for a sample appears two converter clock periods after sampling.
// [R02] Converter clock high is balance phase, low is sampling phase.
// [R03] Sampling ends at converter clock rise, held off by aperture delay.
// [R04] Coarse pass picks ladder sub-range, fine pass resolves low bits next.
// [R05] Each sample maps to one of 1024 straight binary codes, ten bits.
// [R06] Separate range flag; asserting it never alters the data bits.
// [R07] Below range gives zero code, above gives full scale, no wrap.
// [R08] Controller discards one sample when ladder moves over one LSB.
// [R09] Controller may shorten clock low to 150 ns for discarded samples.
// [R10] Controller may use any duty cycle within timing limits.
// [R11] Sleep request freezes data outputs and disconnects lower reference.
// [R12] Output enable low drives result; high releases data and flag.
// [R13] Word and flag update together from a register, stable between.
`timescale 1ns/1ps
`include "tsa_regs.svh"
module tsa_conv_ctrl
  import tsa_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire logic                   conv_clk_in,
  input  wire logic signed [`TSA_SAMPLE_W-1:0] sample_in,
  input  wire logic                   sleep_request_input_in,
  input  wire logic                   output_enable_n_in,
  output      logic [`TSA_DATA_W-1:0] result_word_out,
  output      logic [`TSA_DATA_W-1:0] result_word_oe_out,
  output      logic                   range_exceeded_flag_out,
  output      logic                   range_exceeded_flag_oe_out,
  output      logic                   lower_ref_connect_out,
  output      logic                   balance_phase_out,
  output      logic                   sample_phase_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Clamp a signed sample into the code range and flag excess
  function automatic logic [`TSA_DATA_W:0] clamp_code(
    input logic signed [`TSA_SAMPLE_W-1:0] s);
    logic [`TSA_DATA_W:0] r;
    r = '0;
    if (s < 0) begin
      r = {1'b0, `TSA_CODE_MIN};
    end else if (s > $signed({2'b00, `TSA_CODE_MAX})) begin
      r = {1'b1, `TSA_CODE_MAX};
    end else begin
      r = {1'b0, s[`TSA_DATA_W-1:0]};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  tsa_state_t                   st_r, st_nxt;
  logic                         clk_d_r, clk_d_nxt;
  logic [3:0]                   ap_r, ap_nxt;
  logic                         ap_run_r, ap_run_nxt;
  logic [`TSA_SAMPLE_W-1:0]     held_r, held_nxt;
  logic [`TSA_COARSE_W-1:0]     coarse_r, coarse_nxt;
  logic                         cov_r, cov_nxt;
  logic [`TSA_FINE_W-1:0]       fine_lo_r, fine_lo_nxt;
  tsa_code_t                    fine_code_r, fine_code_nxt;
  logic                         fine_ovf_r, fine_ovf_nxt;
  logic                         fine_vld_r, fine_vld_nxt;
  logic                         res_vld;
  logic                         rise, fall;
  logic [`TSA_DATA_W:0]         cl;
  tsa_code_t                    word_r, word_nxt;
  logic                         flag_r, flag_nxt;
  logic [`TSA_DATA_W-1:0]       w_oe_r, w_oe_nxt;
  logic                         f_oe_r, f_oe_nxt;
  logic                         lref_r, lref_nxt;
  logic                         bal_r, bal_nxt;
  logic                         smp_r, smp_nxt;
  logic                         b_valid, b_ovf;
  tsa_code_t                    b_code;
  tsa_buf_if                    bif ();

  ////////////////////////////////////////////////////////////////////////////
  // Edge detect and phase decode of the converter clock
  always_comb begin
    clk_d_nxt = conv_clk_in;
    rise      = conv_clk_in && !clk_d_r;
    fall      = !conv_clk_in && clk_d_r;
    // [R02] phases from clock level
    bal_nxt   = conv_clk_in;
    smp_nxt   = !conv_clk_in;
  end

  // Aperture delay then sample capture, two-step pipeline
  always_comb begin
    ap_nxt        = ap_r;
    ap_run_nxt    = ap_run_r;
    held_nxt      = held_r;
    st_nxt        = st_r;
    coarse_nxt    = coarse_r;
    cov_nxt       = cov_r;
    fine_code_nxt = fine_code_r;
    fine_ovf_nxt  = fine_ovf_r;
    fine_lo_nxt   = fine_lo_r;
    fine_vld_nxt  = fine_vld_r;
    res_vld       = 1'b0;
    cl            = clamp_code($signed(held_r));
    // [R03] aperture hold after rise
    if (rise) begin
      ap_run_nxt = 1'b1;
      ap_nxt     = 4'h0;
    end else if (ap_run_r) begin
      if (ap_r == 4'(`TSA_APERTURE_CYC - 1)) begin
        ap_run_nxt = 1'b0;
        held_nxt   = sample_in;
      end else begin
        ap_nxt = ap_r + 4'h1;
      end
    end
    // [R01] staged result leaves one full period after the fine pass
    if (rise && fine_vld_r) begin
      res_vld      = 1'b1;
      fine_vld_nxt = 1'b0;
    end
    // [R04] coarse range then fine resolve
    case (st_r)
      TSA_IDLE: begin
        if (rise) begin
          st_nxt = TSA_COARSE;
        end
      end
      TSA_COARSE: begin
        if (fall) begin
          // [R05] [R07] clamp to binary range
          coarse_nxt  = cl[`TSA_DATA_W-1:`TSA_FINE_W];
          fine_lo_nxt = cl[`TSA_FINE_W-1:0];
          cov_nxt     = cl[`TSA_DATA_W];
          st_nxt     = TSA_FINE;
        end
      end
      TSA_FINE: begin
        if (rise) begin
          // Fine bits joined to the coarse range here, on the rise that ends the fine pass
          fine_code_nxt = {coarse_r, fine_lo_r};
          fine_ovf_nxt  = cov_r;
          fine_vld_nxt  = 1'b1;
          st_nxt        = TSA_COARSE;
        end
      end
      default: begin
        st_nxt = TSA_IDLE;
      end
    endcase
  end

  // Buffer source side; results arriving while both entries are full are lost
  assign bif.valid = res_vld;
  assign bif.code  = fine_code_r;
  assign bif.ovf   = fine_ovf_r;

  tsa_out_buf u_buf (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .up            (bif),
    .out_valid_out (b_valid),
    .out_ready_in  (!sleep_request_input_in),
    .out_code_out  (b_code),
    .out_ovf_out   (b_ovf)
  );

  // Output stage next values
  always_comb begin
    word_nxt = word_r;
    flag_nxt = flag_r;
    // [R13] word and flag move together
    // [R11] sleep freezes word and flag
    if (b_valid && !sleep_request_input_in) begin
      // [R06] flag kept apart from data
      word_nxt = b_code;
      flag_nxt = b_ovf;
    end
    // [R12] active-low output enable
    w_oe_nxt = {`TSA_DATA_W{!output_enable_n_in}};
    f_oe_nxt = !output_enable_n_in;
    // [R11] lower reference released in sleep
    lref_nxt = !sleep_request_input_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_r        <= TSA_IDLE;
      clk_d_r     <= 1'b0;
      ap_r        <= 4'h0;
      ap_run_r    <= 1'b0;
      held_r      <= '0;
      coarse_r    <= '0;
      cov_r       <= 1'b0;
      fine_code_r <= '0;
      fine_ovf_r  <= 1'b0;
      fine_lo_r   <= '0;
      fine_vld_r  <= 1'b0;
      word_r      <= '0;
      flag_r      <= 1'b0;
      w_oe_r      <= '0;
      f_oe_r      <= 1'b0;
      lref_r      <= 1'b1;
      bal_r       <= 1'b0;
      smp_r       <= 1'b1;
    end else begin
      st_r        <= st_nxt;
      clk_d_r     <= clk_d_nxt;
      ap_r        <= ap_nxt;
      ap_run_r    <= ap_run_nxt;
      held_r      <= held_nxt;
      coarse_r    <= coarse_nxt;
      cov_r       <= cov_nxt;
      fine_code_r <= fine_code_nxt;
      fine_ovf_r  <= fine_ovf_nxt;
      fine_lo_r   <= fine_lo_nxt;
      fine_vld_r  <= fine_vld_nxt;
      word_r      <= word_nxt;
      flag_r      <= flag_nxt;
      w_oe_r      <= w_oe_nxt;
      f_oe_r      <= f_oe_nxt;
      lref_r      <= lref_nxt;
      bal_r       <= bal_nxt;
      smp_r       <= smp_nxt;
    end
  end

  assign result_word_out            = word_r;
  assign range_exceeded_flag_out    = flag_r;
  assign result_word_oe_out         = w_oe_r;
  assign range_exceeded_flag_oe_out = f_oe_r;
  assign lower_ref_connect_out      = lref_r;
  assign balance_phase_out          = bal_r;
  assign sample_phase_out           = smp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  phase_follow_a: assert property ( // [R02]
    ##1 balance_phase_out == $past(conv_clk_in) && sample_phase_out == !$past(conv_clk_in))
    else $error("phase outputs do not follow converter clock");
  aperture_hold_a: assert property (rise |-> ##1 ap_run_r [*7] ##1 !ap_run_r) // [R03]
    else $error("aperture delay length wrong");
  code_clamp_a: assert property ( // [R07]
    st_r == TSA_COARSE && fall && $signed(held_r) < 0
    |=> coarse_r == 4'h0 && fine_lo_r == 6'h00 && !cov_r)
    else $error("negative input not clamped to zero");
  over_clamp_a: assert property ( // [R07]
    st_r == TSA_COARSE && fall && $signed(held_r) > 12'sh3FF
    |=> coarse_r == 4'hF && fine_lo_r == 6'h3F && cov_r)
    else $error("over range not clamped to full scale");
  sleep_freeze_a: assert property ( // [R11]
    sleep_request_input_in |=> $stable(result_word_out) && $stable(range_exceeded_flag_out))
    else $error("outputs changed during sleep");
  sleep_ref_a: assert property (sleep_request_input_in |=> !lower_ref_connect_out) // [R11]
    else $error("lower reference not released in sleep");
  oe_drive_a: assert property ( // [R12]
    output_enable_n_in |=> result_word_oe_out == 10'h000 && !range_exceeded_flag_oe_out)
    else $error("outputs driven while disabled");
  pair_update_a: assert property ( // [R13]
    $changed(range_exceeded_flag_out) |-> $past(b_valid) && !$past(sleep_request_input_in))
    else $error("flag changed without a word update");
  result_slot_a: assert property ( // [R01]
    res_vld |-> $past(fine_vld_r, 8) && bif.code == $past(fine_code_r, 8))
    else $error("result left less than a converter period after staging");
  fine_step_a: assert property (st_r == TSA_COARSE && fall |=> st_r == TSA_FINE) // [R04]
    else $error("fine pass not entered after coarse");
  flag_sep_a: assert property (res_vld && bif.ovf |-> bif.code == 10'h3FF) // [R06]
    else $error("flag altered the data bits");

  conv_done_c: cover property (res_vld);
  over_c: cover property (res_vld && bif.ovf);
  sleep_c: cover property (sleep_request_input_in && b_valid);
  oe_c: cover property (!output_enable_n_in ##1 output_enable_n_in);
endmodule

// ### verif/tsa_host_model.sv
// Host side model: drives converter clock and analog sample word
// Assumes the bench calls its tasks; changes land on clk_in falling edges
`timescale 1ns/1ps
`include "tsa_regs.svh"
module tsa_host_model (
  input  wire logic                           clk_in,
  output      logic                           conv_clk_out,
  output      logic signed [`TSA_SAMPLE_W-1:0] sample_out
);
  ////////////////////////////////////////////////////////////////////////
  // Idle: clock low, sample at zero
  initial begin
    conv_clk_out = 1'b0;
    sample_out   = 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////
  // any duty cycle
  // Holds the converter clock level for a chosen number of cycles
  task automatic hold_level(input logic lvl, input int cycles);
    @(negedge clk_in);
    conv_clk_out = lvl;
    repeat (cycles - 1) @(negedge clk_in);
  endtask

  // shortened low phase
  // Sample taken here is thrown away by the host, so low may be short
  task automatic discard_period(input logic signed [`TSA_SAMPLE_W-1:0] s);
    @(negedge clk_in);
    sample_out = s;
    hold_level(1'b1, 8);
    hold_level(1'b0, 8);
  endtask

  // Sets the analog input word
  task automatic set_sample(input logic signed [`TSA_SAMPLE_W-1:0] s);
    @(negedge clk_in);
    sample_out = s;
  endtask
endmodule

// ### verif/testbench.sv
// Self-checking bench for the two-step converter control block
// Assumes design files and package compiled first; one 200 MHz clock
`timescale 1ns/1ps
`include "tsa_regs.svh"
module testbench;
  import tsa_pkg::*;
  logic                            clk_in;
  logic                            reset_in;
  logic                            conv_clk;
  logic                            sleep_in;
  logic                            oe_n;
  logic signed [`TSA_SAMPLE_W-1:0] sample;
  tsa_code_t                       word;
  tsa_code_t                       word_oe;
  logic                            flag;
  logic                            flag_oe;
  logic                            lref;
  logic                            bal;
  logic                            smp;
  int                              err_total;
  int                              comparisons;
  logic [11:0] in_tab  [10] = '{12'h000, 12'h001, 12'h03F, 12'h040, 12'h200,
                                12'h3FF, 12'h400, 12'h7FF, 12'hFFF, 12'h800};
  logic [9:0]  exp_tab [10] = '{10'h000, 10'h001, 10'h03F, 10'h040, 10'h200,
                                10'h3FF, 10'h3FF, 10'h3FF, 10'h000, 10'h000};
  logic        ovf_tab [10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  tsa_conv_ctrl tsa_conv_ctrl_inst (
    .clk_in                     (clk_in),
    .reset_in                   (reset_in),
    .conv_clk_in                (conv_clk),
    .sample_in                  (sample),
    .sleep_request_input_in     (sleep_in),
    .output_enable_n_in         (oe_n),
    .result_word_out            (word),
    .result_word_oe_out         (word_oe),
    .range_exceeded_flag_out    (flag),
    .range_exceeded_flag_oe_out (flag_oe),
    .lower_ref_connect_out      (lref),
    .balance_phase_out          (bal),
    .sample_phase_out           (smp)
  );

  tsa_host_model tsa_host_model_inst (
    .clk_in       (clk_in),
    .conv_clk_out (conv_clk),
    .sample_out   (sample)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  initial begin
    #100000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare, conversion and reporting tasks
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conv(input int n);
    repeat (n) begin
      tsa_host_model_inst.hold_level(1'b1, 10);
      tsa_host_model_inst.hold_level(1'b0, 12);
    end
    repeat (4) @(negedge clk_in);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    reset_in    = 1'b1;
    sleep_in    = 1'b0;
    oe_n        = 1'b1;
    err_total   = 0;
    comparisons = 0;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk(word, 10'h000);
    chk({9'h000, flag}, 10'h000);
    chk(word_oe, 10'h000);
    chk({8'h00, lref, smp}, 10'h003);
    chk({9'h000, bal}, 10'h000);
    reset_in = 1'b0;
    $display("test reset done");
    // Phases follow the converter clock
    tsa_host_model_inst.hold_level(1'b1, 8);
    chk({8'h00, bal, smp}, 10'h002);
    tsa_host_model_inst.hold_level(1'b0, 8);
    chk({8'h00, bal, smp}, 10'h001);
    $display("test phases done");
    // Code table incl. clamps and range flag; old code still out after two periods
    for (int i = 0; i < 10; i++) begin
      tsa_host_model_inst.set_sample(in_tab[i]);
      conv(2);
      chk(word, (i == 0) ? 10'h000 : exp_tab[i-1]);
      conv(1);
      chk(word, exp_tab[i]);
      chk({9'h000, flag}, {9'h000, ovf_tab[i]});
    end
    repeat (20) @(negedge clk_in);
    chk(word, 10'h000);
    chk({9'h000, flag}, 10'h000);
    $display("test codes done");
    // Output drive enables
    oe_n = 1'b0;
    repeat (3) @(negedge clk_in);
    chk(word_oe, 10'h3FF);
    chk({9'h000, flag_oe}, 10'h001);
    oe_n = 1'b1;
    repeat (3) @(negedge clk_in);
    chk(word_oe, 10'h000);
    chk({9'h000, flag_oe}, 10'h000);
    $display("test enables done");
    // Sleep freezes the word while the buffer fills
    sleep_in = 1'b1;
    tsa_host_model_inst.set_sample(12'h155);
    conv(4);
    chk(word, 10'h000);
    chk({9'h000, lref}, 10'h000);
    sleep_in = 1'b0;
    conv(4);
    chk(word, 10'h155);
    chk({9'h000, flag}, 10'h000);
    chk({9'h000, lref}, 10'h001);
    $display("test sleep done");
    // Host throws one sample away, next one must convert cleanly
    tsa_host_model_inst.discard_period(12'h0AA);
    tsa_host_model_inst.set_sample(12'h3BB);
    conv(3);
    chk(word, 10'h3BB);
    chk({9'h000, flag}, 10'h000);
    $display("test discard done");
    print_verdict();
  end
endmodule
